// File: acpd_cal_start.sv
`timescale 1ns/100ps
module acpd_cal_start #(
    parameter int unsigned LOW_MIN  = acpd_pkg::CAL_LOW_MIN,
    parameter int unsigned HIGH_MIN = acpd_pkg::CAL_HIGH_MIN
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic pin_i,
    input  wire logic enable,
    output logic      start_o
);

    localparam int unsigned LW = $clog2(LOW_MIN + 1);
    localparam int unsigned HW = $clog2(HIGH_MIN + 1);

    logic [LW-1:0] lo_cnt_d;
    logic [LW-1:0] lo_cnt_q;
    logic [HW-1:0] hi_cnt_d;
    logic [HW-1:0] hi_cnt_q;
    logic          start_d;
    logic          start_q;

    // Low phase must complete before high cycles count; a fire needs a new low phase.
    always_comb begin
        lo_cnt_d = lo_cnt_q;
        hi_cnt_d = '0;
        start_d  = 1'b0;
        if (!enable) begin
            lo_cnt_d = '0;
        end else if (!pin_i) begin
            if (lo_cnt_q != LW'(LOW_MIN)) begin
                lo_cnt_d = lo_cnt_q + LW'(1); // R2
            end
        end else if (lo_cnt_q == LW'(LOW_MIN)) begin
            hi_cnt_d = hi_cnt_q + HW'(1);
            if (hi_cnt_q == HW'(HIGH_MIN - 1)) begin
                start_d  = 1'b1; // R2
                lo_cnt_d = '0;
                hi_cnt_d = '0;
            end
        end else begin
            lo_cnt_d = '0;
        end
    end

    // Counter and pulse registers.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lo_cnt_q <= '0;
            hi_cnt_q <= '0;
            start_q  <= 1'b0;
        end else begin
            lo_cnt_q <= lo_cnt_d;
            hi_cnt_q <= hi_cnt_d;
            start_q  <= start_d;
        end
    end

    assign start_o = start_q;

    cal_pin_start_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R2
        start_q |-> $past(pin_i) && $past(enable) && ($past(hi_cnt_q) == HW'(HIGH_MIN - 1)))
        else $error("Calibration start fired without a full high phase.");

endmodule : acpd_cal_start

// File: acpd_host.sv
`timescale 1ns/100ps
// Host logic that drives the control pins; every change lands 1 ns after a rising edge.
module acpd_host (
    input  wire logic               sys_clk,
    output acpd_pkg::acpd_tri_raw_t edge_sel,
    output acpd_pkg::acpd_tri_raw_t range_sel,
    output acpd_pkg::acpd_tri_raw_t rst_type,
    output acpd_pkg::acpd_tri_raw_t ece,
    output acpd_pkg::acpd_tri_raw_t cal_dly,
    output logic                    amp,
    output logic                    pd,
    output logic                    cal,
    output logic                    sync_rst
);
    localparam acpd_pkg::acpd_tri_raw_t LO = 2'b01;
    localparam acpd_pkg::acpd_tri_raw_t HI = 2'b10;

    // Idle levels: non-extended mode, single-ended reset, higher range.
    initial begin
        {edge_sel, range_sel, rst_type, ece, cal_dly} = {5{HI}};
        {amp, pd, cal, sync_rst} = 4'b1000;
    end

    // Waits n edges, then steps 1 ns off the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // Low phase then high phase on the calibration pin.
    task automatic cal_seq(input int lo, input int hi);
        cal = 1'b0;
        tick(lo);
        cal = 1'b1;
        tick(hi);
        cal = 1'b0;
    endtask : cal_seq

    // One positive reset pulse; the differential form also pulls the negative leg low.
    task automatic sync_pulse(input logic diff);
        sync_rst = 1'b1;
        if (diff) range_sel = LO;
        tick(4);
        sync_rst = 1'b0;
        range_sel = HI;
        tick(4);
    endtask : sync_pulse

    // One serial frame, MSB first; the clock stands still low outside the frame.
    task automatic ser_write(input logic [23:0] frame);
        amp = 1'b0;
        cal_dly = LO;
        tick(4);
        for (int i = 23; i >= 0; i--) begin
            edge_sel = frame[i] ? HI : LO;
            tick(4);
            amp = 1'b1;
            tick(4);
            amp = 1'b0;
        end
        tick(4);
        cal_dly = HI;
        edge_sel = frame[0] ? LO : HI;
        tick(8);
    endtask : ser_write
endmodule : acpd_host

// File: acpd_pkg.sv
package acpd_pkg;

    // Decoded state of a three-level control pin.
    typedef enum logic [1:0] {
        LVL_LOW,
        LVL_MID,
        LVL_HIGH
    } acpd_lvl_t;

    // Two comparator outputs from the pin's analogue level detector.
    typedef struct packed {
        logic above_hi;
        logic below_lo;
    } acpd_tri_raw_t;

    // Mode word driven to the converter core, one flop per field.
    typedef struct packed {
        logic power_down;
        logic ext_mode;
        logic alt_ext_enable;
        logic ddr_enable;
        logic edge_rising;
        logic range_high;
        logic diff_reset;
        logic cal_delay_long;
    } acpd_mode_t;

    // Calibration register location and layout.
    localparam logic [7:0]  CAL_CTRL_ADDR  = 8'h00;
    localparam int unsigned CAL_BIT        = 15;
    localparam logic [15:0] CAL_CTRL_RESET = 16'h0000;

    // Serial frame: eight address bits, then sixteen data bits, MSB first.
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned ADDR_MSB   = 23;
    localparam int unsigned ADDR_LSB   = 16;
    localparam int unsigned DATA_MSB   = 15;

    // Calibration timing in input clock cycles.
    localparam int unsigned CAL_LOW_MIN    = 16;
    localparam int unsigned CAL_HIGH_MIN   = 16;
    localparam int unsigned CAL_RUN_CYCLES = 1024;

    // Values after reset.
    localparam acpd_lvl_t LVL_RESET = LVL_MID;

    // Comparator pair to level; a pair with both set or both clear counts as mid-supply.
    function automatic acpd_lvl_t decode_level(input acpd_tri_raw_t raw);
        if (raw.below_lo && !raw.above_hi) begin
            return LVL_LOW;
        end else if (raw.above_hi && !raw.below_lo) begin
            return LVL_HIGH;
        end
        return LVL_MID;
    endfunction : decode_level

endpackage : acpd_pkg

// File: acpd_top.sv
// Behaviour
// [R1] Power-down pin high puts every channel and function into power down.
// [R2] Start calibration after a minimum low count then minimum high count on the pin.
// [R3] Writing the calibration bit at register address zero also starts calibration.
// [R4] Outside extended mode, edge-select level picks the output clock edge.
// [R5] Edge-select floating or mid-supply enables double-data-rate output clocking.
// [R6] In extended mode the edge-select pin carries serial configuration data.
// [R7] Single-ended reset mode: positive pulse on reset pin resyncs output clocks.
// [R8] Reset-type low: output-clock reset is a differential pulse, reset pin positive.
// [R9] In differential reset mode the range pin is the negative reset polarity.
// [R10] Range pin acts only with reset-type floating/high and primary enable floating.
// [R11] Range pin low selects reduced full-scale range, high selects the higher range.
// [R12] Range pin floating or mid-supply enters extended control mode.
// [R13] Primary extended-control enable overrides the enable derived from the range pin.
// [R14] Differential reset mode has no range pin control and uses the higher range.
// [R15] In extended mode the output-amplitude pin is the serial clock.
// [R16] In extended mode the calibration-delay pin is the serial chip select.
// [R17] Every three-level pin decodes into low, high, or floating/mid-supply.
`timescale 1ns/100ps
module acpd_top #(
    parameter int unsigned CAL_LOW_MIN    = acpd_pkg::CAL_LOW_MIN,
    parameter int unsigned CAL_HIGH_MIN   = acpd_pkg::CAL_HIGH_MIN,
    parameter int unsigned CAL_RUN_CYCLES = acpd_pkg::CAL_RUN_CYCLES
) (
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    input  wire acpd_pkg::acpd_tri_raw_t output_edge_select,
    input  wire acpd_pkg::acpd_tri_raw_t input_range_select,
    input  wire acpd_pkg::acpd_tri_raw_t reset_type_select,
    input  wire acpd_pkg::acpd_tri_raw_t ext_control_enable,
    input  wire acpd_pkg::acpd_tri_raw_t calibration_delay_select,
    input  wire logic                    output_amplitude_select,
    input  wire logic                    device_power_down,
    input  wire logic                    calibration_start,
    input  wire logic                    output_clock_sync_reset,
    output acpd_pkg::acpd_mode_t         mode,
    output logic                         amplitude_normal,
    output logic                         output_clock_sync_pulse,
    output logic                         calibration_busy,
    output logic [15:0]                  calibration_control
);

    localparam int unsigned NSYNC = 4;
    localparam int unsigned RW    = $clog2(CAL_RUN_CYCLES + 1);
    localparam int unsigned CW    = $clog2(acpd_pkg::FRAME_BITS + 2);

    typedef enum logic {
        CAL_IDLE,
        CAL_RUN
    } acpd_cal_state_t;

    acpd_pkg::acpd_lvl_t   edge_lvl;
    acpd_pkg::acpd_lvl_t   range_lvl;
    acpd_pkg::acpd_lvl_t   rtype_lvl;
    acpd_pkg::acpd_lvl_t   ece_lvl;
    acpd_pkg::acpd_lvl_t   cdly_lvl;

    logic [NSYNC-1:0]      pin_raw;
    logic [NSYNC-1:0]      meta_q;
    logic [NSYNC-1:0]      sync_q;
    logic                  pd_s;
    logic                  cal_s;
    logic                  rst_s;
    logic                  sclk_s;

    acpd_pkg::acpd_mode_t  mode_d;
    acpd_pkg::acpd_mode_t  mode_q;
    logic                  amp_d;
    logic                  amp_q;

    logic                  trig_lvl;
    logic                  trig_prev_q;
    logic                  pulse_d;
    logic                  pulse_q;

    logic                  sel_act;
    logic                  serial_config_data_in;
    logic                  sclk_prev_q;
    logic                  sel_prev_q;
    logic [23:0]           shift_d;
    logic [23:0]           shift_q;
    logic [CW-1:0]         cnt_d;
    logic [CW-1:0]         cnt_q;
    logic                  wr_en;

    logic                  pin_start;
    acpd_cal_state_t       cal_st_d;
    acpd_cal_state_t       cal_st_q;
    logic [RW-1:0]         run_cnt_d;
    logic [RW-1:0]         run_cnt_q;
    logic [15:0]           ctrl_d;
    logic [15:0]           ctrl_q;
    logic                  reg_start_d;
    logic                  reg_start_q;
    logic                  cal_done;

    // Three-level pins, each synchronised and decoded in its own instance.
    acpd_tri_in u_edge (.sys_clk(sys_clk), .resetn(resetn),
                        .pin_raw(output_edge_select), .level(edge_lvl));
    acpd_tri_in u_range (.sys_clk(sys_clk), .resetn(resetn),
                         .pin_raw(input_range_select), .level(range_lvl));
    acpd_tri_in u_rtype (.sys_clk(sys_clk), .resetn(resetn),
                         .pin_raw(reset_type_select), .level(rtype_lvl));
    acpd_tri_in u_ece (.sys_clk(sys_clk), .resetn(resetn),
                       .pin_raw(ext_control_enable), .level(ece_lvl));
    acpd_tri_in u_cdly (.sys_clk(sys_clk), .resetn(resetn),
                        .pin_raw(calibration_delay_select), .level(cdly_lvl));

    assign pin_raw = {output_amplitude_select, output_clock_sync_reset,
                      calibration_start, device_power_down};

    // Two-level pins come from outside the clock domain and pass two flops each.
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= pin_raw[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign pd_s   = sync_q[0];
    assign cal_s  = sync_q[1];
    assign rst_s  = sync_q[2];
    assign sclk_s = sync_q[3];

    // Mode decode: reset type first, then the primary enable, then the range pin.
    always_comb begin
        mode_d                = '0;
        mode_d.power_down     = pd_s; // R1
        mode_d.diff_reset     = (rtype_lvl == acpd_pkg::LVL_LOW); // R8
        mode_d.alt_ext_enable = !mode_d.diff_reset && (ece_lvl == acpd_pkg::LVL_MID)
                                && (range_lvl == acpd_pkg::LVL_MID); // R10 R12
        if (ece_lvl == acpd_pkg::LVL_LOW) begin
            mode_d.ext_mode = 1'b1; // R13
        end else if (ece_lvl == acpd_pkg::LVL_HIGH) begin
            mode_d.ext_mode = 1'b0; // R13
        end else begin
            mode_d.ext_mode = mode_d.alt_ext_enable; // R12
        end
        // Differential mode leaves no pin for the range, so it defaults high.
        if (mode_d.diff_reset || ece_lvl != acpd_pkg::LVL_MID) begin
            mode_d.range_high = 1'b1; // R14
        end else begin
            mode_d.range_high = (range_lvl != acpd_pkg::LVL_LOW); // R11
        end
        mode_d.ddr_enable     = !mode_d.ext_mode && (edge_lvl == acpd_pkg::LVL_MID); // R5
        mode_d.edge_rising    = !mode_d.ext_mode && (edge_lvl == acpd_pkg::LVL_HIGH); // R4
        mode_d.cal_delay_long = !mode_d.ext_mode && (cdly_lvl == acpd_pkg::LVL_HIGH);
        amp_d                 = mode_d.ext_mode ? 1'b1 : sclk_s;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= '0;
            amp_q  <= 1'b1;
        end else begin
            mode_q <= mode_d;
            amp_q  <= amp_d;
        end
    end

    // Output-clock reset. The negative leg comes through the level decoder and so
    // lags the positive leg by one cycle; the pulse must be wider than that.
    always_comb begin
        if (mode_d.diff_reset) begin
            trig_lvl = rst_s && (range_lvl == acpd_pkg::LVL_LOW); // R8 R9
        end else begin
            trig_lvl = rst_s; // R7
        end
        pulse_d = trig_lvl && !trig_prev_q;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            trig_prev_q <= 1'b0;
            pulse_q     <= 1'b0;
        end else begin
            trig_prev_q <= trig_lvl;
            pulse_q     <= pulse_d;
        end
    end

    // Serial shifter. The serial clock is oversampled, so it must stay well below
    // the system clock and data must be stable a few cycles around its rising edge.
    always_comb begin
        sel_act = mode_d.ext_mode && (cdly_lvl == acpd_pkg::LVL_LOW); // R16
        serial_config_data_in   = (edge_lvl == acpd_pkg::LVL_HIGH); // R6
        shift_d = shift_q;
        cnt_d   = cnt_q;
        wr_en   = 1'b0;
        if (sel_act) begin
            if (sclk_s && !sclk_prev_q) begin
                shift_d = {shift_q[22:0], serial_config_data_in}; // R15 R6
                if (cnt_q != CW'(acpd_pkg::FRAME_BITS + 1)) begin
                    cnt_d = cnt_q + CW'(1);
                end
            end
        end else begin
            cnt_d = '0;
            // Only an exact-length frame addressed to the calibration register writes.
            wr_en = sel_prev_q && (cnt_q == CW'(acpd_pkg::FRAME_BITS))
                    && (shift_q[acpd_pkg::ADDR_MSB:acpd_pkg::ADDR_LSB]
                        == acpd_pkg::CAL_CTRL_ADDR); // R3
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_prev_q <= 1'b0;
            sel_prev_q  <= 1'b0;
            shift_q     <= '0;
            cnt_q       <= '0;
        end else begin
            sclk_prev_q <= sclk_s;
            sel_prev_q  <= sel_act;
            shift_q     <= shift_d;
            cnt_q       <= cnt_d;
        end
    end

    // Pin-initiated calibration start detector.
    acpd_cal_start #(
        .LOW_MIN  (CAL_LOW_MIN),
        .HIGH_MIN (CAL_HIGH_MIN)
    ) u_cal_start (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .pin_i   (cal_s),
        .enable  (!pd_s),
        .start_o (pin_start)
    );

    // Calibration sequencer and register. A write in the finishing cycle wins over
    // the hardware clear of the calibration bit.
    always_comb begin
        cal_st_d    = cal_st_q;
        run_cnt_d   = run_cnt_q;
        ctrl_d      = ctrl_q;
        reg_start_d = 1'b0;
        cal_done    = 1'b0;
        unique case (cal_st_q)
            CAL_IDLE: begin
                run_cnt_d = '0;
                if (!pd_s && (pin_start || reg_start_q)) begin
                    cal_st_d = CAL_RUN; // R2 R3
                end
            end
            CAL_RUN: begin
                run_cnt_d = run_cnt_q + RW'(1);
                if (pd_s || run_cnt_q == RW'(CAL_RUN_CYCLES - 1)) begin
                    cal_st_d = CAL_IDLE; // R1
                    cal_done = 1'b1;
                end
            end
        endcase
        if (cal_done) begin
            ctrl_d[acpd_pkg::CAL_BIT] = 1'b0;
        end
        if (wr_en) begin
            ctrl_d      = shift_q[acpd_pkg::DATA_MSB:0];
            reg_start_d = shift_q[acpd_pkg::CAL_BIT] && !ctrl_q[acpd_pkg::CAL_BIT]; // R3
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cal_st_q    <= CAL_IDLE;
            run_cnt_q   <= '0;
            ctrl_q      <= acpd_pkg::CAL_CTRL_RESET;
            reg_start_q <= 1'b0;
        end else begin
            cal_st_q    <= cal_st_d;
            run_cnt_q   <= run_cnt_d;
            ctrl_q      <= ctrl_d;
            reg_start_q <= reg_start_d;
        end
    end

    assign mode                    = mode_q;
    assign amplitude_normal        = amp_q;
    assign output_clock_sync_pulse = pulse_q;
    assign calibration_busy        = (cal_st_q == CAL_RUN);
    assign calibration_control     = ctrl_q;

    pd_mode_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R1
        pd_s |=> mode_q.power_down && (cal_st_q == CAL_IDLE))
        else $error("Power down not reflected or calibration not stopped.");

    reg_cal_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R3
        (reg_start_q && cal_st_q == CAL_IDLE && !pd_s) |=> cal_st_q == CAL_RUN)
        else $error("Register calibration request did not start a run.");

    edge_sel_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R4
        (!mode_d.ext_mode && edge_lvl != acpd_pkg::LVL_MID)
        |=> mode_q.edge_rising == ($past(edge_lvl) == acpd_pkg::LVL_HIGH) && !mode_q.ddr_enable)
        else $error("Output edge select not followed.");

    ddr_sel_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R5
        mode_q.ddr_enable |-> !mode_q.ext_mode && $past(edge_lvl) == acpd_pkg::LVL_MID)
        else $error("Double data rate enabled without a mid-level edge pin.");

    serial_config_data_in_shift_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R6
        (sel_act && sclk_s && !sclk_prev_q) |=> shift_q[0] == $past(serial_config_data_in))
        else $error("Serial data bit not captured on serial clock edge.");

    se_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R7
        (!mode_d.diff_reset && $rose(rst_s) && !trig_prev_q) |=> pulse_q ##1 !pulse_q)
        else $error("Single-ended reset pulse not issued as one cycle.");

    diff_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R9
        (mode_d.diff_reset && pulse_d) |-> rst_s && range_lvl == acpd_pkg::LVL_LOW)
        else $error("Differential reset fired without both legs asserted.");

    range_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R10
        mode_q.alt_ext_enable |-> !mode_q.diff_reset && $past(ece_lvl) == acpd_pkg::LVL_MID)
        else $error("Alternate enable taken while range pin is not in range role.");

    range_sel_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R14
        (mode_d.diff_reset || range_lvl == acpd_pkg::LVL_HIGH) |=> mode_q.range_high)
        else $error("Higher range not selected.");

    ece_prec_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R13
        (ece_lvl == acpd_pkg::LVL_HIGH) |=> !mode_q.ext_mode && !$past(sel_act))
        else $error("Primary enable did not override alternate enable.");

endmodule : acpd_top

// File: acpd_tri_in.sv
`timescale 1ns/100ps
module acpd_tri_in (
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    input  wire acpd_pkg::acpd_tri_raw_t pin_raw,
    output acpd_pkg::acpd_lvl_t         level
);

    acpd_pkg::acpd_tri_raw_t meta_q;
    acpd_pkg::acpd_tri_raw_t sync_q;
    acpd_pkg::acpd_lvl_t     level_d;
    acpd_pkg::acpd_lvl_t     level_q;

    // Only the second stage is decoded, so a metastable first stage never leaks.
    always_comb begin
        level_d = acpd_pkg::decode_level(sync_q); // R17
    end

    // Two-stage synchroniser followed by the decoded level register.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q  <= '0;
            sync_q  <= '0;
            level_q <= acpd_pkg::LVL_RESET;
        end else begin
            meta_q  <= pin_raw;
            sync_q  <= meta_q;
            level_q <= level_d;
        end
    end

    assign level = level_q;

    tri_decode_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R17
        ##1 (level_q == acpd_pkg::decode_level($past(sync_q))))
        else $error("Decoded level does not follow synchronised comparators.");

endmodule : acpd_tri_in

// File: tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
    localparam acpd_pkg::acpd_tri_raw_t LO = 2'b01;
    localparam acpd_pkg::acpd_tri_raw_t HI = 2'b10;
    localparam acpd_pkg::acpd_tri_raw_t MD = 2'b00;
    logic                    sys_clk;
    logic                    resetn;
    acpd_pkg::acpd_tri_raw_t edge_sel;
    acpd_pkg::acpd_tri_raw_t range_sel;
    acpd_pkg::acpd_tri_raw_t rst_type;
    acpd_pkg::acpd_tri_raw_t ece;
    acpd_pkg::acpd_tri_raw_t cal_dly;
    logic                    amp;
    logic                    pd;
    logic                    cal;
    logic                    sync_rst;
    acpd_pkg::acpd_mode_t    mode;
    logic                    amplitude_normal;
    logic                    output_clock_sync_pulse;
    logic                    calibration_busy;
    logic [15:0]             calibration_control;
    logic [15:0]             ctl_at_start;
    int                      n_fail = 0;
    int                      compares = 0;
    int                      n_pulse = 0;
    int                      n_runs = 0;
    int                      run = 0;
    int                      last_len = 0;
    acpd_pkg::acpd_tri_raw_t t_ece [7] = '{MD, MD, MD, HI, HI, MD, LO};
    acpd_pkg::acpd_tri_raw_t t_rt  [7] = '{HI, HI, HI, HI, HI, LO, HI};
    acpd_pkg::acpd_tri_raw_t t_rng [7] = '{LO, HI, MD, MD, LO, LO, HI};
    logic [2:0]              t_exp [7] = '{3'h0, 3'h2, 3'h6, 3'h2, 3'h2, 3'h3, 3'h6};
    // The last entry has both comparators set, which must decode as mid-supply.
    acpd_pkg::acpd_tri_raw_t t_edge [4] = '{LO, HI, MD, 2'h3};

    acpd_host host_i (.sys_clk(sys_clk), .edge_sel(edge_sel), .range_sel(range_sel),
        .rst_type(rst_type), .ece(ece), .cal_dly(cal_dly), .amp(amp), .pd(pd),
        .cal(cal), .sync_rst(sync_rst));

    // Counts shortened for simulation: 4 low, 4 high, 8 run cycles.
    acpd_top #(.CAL_LOW_MIN(4), .CAL_HIGH_MIN(4), .CAL_RUN_CYCLES(8)) acpd_top_i (
        .sys_clk(sys_clk), .resetn(resetn), .output_edge_select(edge_sel),
        .input_range_select(range_sel), .reset_type_select(rst_type),
        .ext_control_enable(ece), .calibration_delay_select(cal_dly),
        .output_amplitude_select(amp), .device_power_down(pd),
        .calibration_start(cal), .output_clock_sync_reset(sync_rst), .mode(mode),
        .amplitude_normal(amplitude_normal),
        .output_clock_sync_pulse(output_clock_sync_pulse),
        .calibration_busy(calibration_busy), .calibration_control(calibration_control));

    // The clock, 20 ns period.
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Measures busy runs and sync pulses, so short or doubled ones show up.
    always @(posedge sys_clk) begin
        if (calibration_busy === 1'b1) begin
            if (run == 0) ctl_at_start = calibration_control;
            run++;
        end else if (run != 0) begin
            last_len = run;
            n_runs++;
            run = 0;
        end
        if (output_clock_sync_pulse === 1'b1) n_pulse++;
    end

    task automatic final_report();
        if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report

    // Pin to mode takes four edges; six leave margin.
    task automatic settle();
        host_i.tick(6);
    endtask : settle

    // Main sequence of tests.
    initial begin
        resetn = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 resetn = 1'b1;
        `CHK(calibration_control, 16'h0000)
        `CHK(calibration_busy, 1'b0)
        settle();
        `CHK(mode.cal_delay_long, 1'b1)
        `CHK(amplitude_normal, 1'b1)
        for (int i = 0; i < 4; i++) begin
            host_i.edge_sel = t_edge[i];
            settle();
            `CHK(mode.ddr_enable, i >= 2)
            if (i < 2) `CHK(mode.edge_rising, i == 1)
        end
        for (int i = 0; i < 7; i++) begin
            {host_i.ece, host_i.rst_type, host_i.range_sel} = {t_ece[i], t_rt[i], t_rng[i]};
            settle();
            `CHK({mode.ext_mode, mode.range_high, mode.diff_reset}, t_exp[i])
            if (i == 2) `CHK(mode.alt_ext_enable, 1'b1)
        end
        {host_i.ece, host_i.range_sel, host_i.amp} = {HI, HI, 1'b0};
        settle();
        `CHK(amplitude_normal, 1'b0)
        host_i.sync_pulse(1'b0);
        host_i.tick(4);
        `CHK(n_pulse, 1)
        host_i.rst_type = LO;
        settle();
        host_i.sync_pulse(1'b1);
        host_i.sync_rst = 1'b1;
        host_i.tick(4);
        host_i.sync_rst = 1'b0;
        host_i.tick(6);
        `CHK(n_pulse, 2)
        host_i.rst_type = HI;
        settle();
        host_i.cal_seq(4, 4);
        host_i.tick(30);
        `CHK(n_runs, 1)
        `CHK(last_len, 8)
        host_i.cal_seq(4, 2);
        host_i.tick(30);
        `CHK(n_runs, 1)
        host_i.cal_seq(4, 4);
        host_i.tick(4);
        host_i.pd = 1'b1;
        settle();
        `CHK(mode.power_down, 1'b1)
        `CHK(calibration_busy, 1'b0)
        `CHK(last_len < 8, 1'b1)
        host_i.cal_seq(4, 4);
        host_i.tick(20);
        `CHK(n_runs, 2)
        host_i.pd = 1'b0;
        host_i.ece = LO;
        host_i.tick(30);
        `CHK(mode.power_down, 1'b0)
        `CHK(mode.cal_delay_long, 1'b0)
        `CHK(amplitude_normal, 1'b1)
        host_i.ser_write({8'h01, 16'h8000});
        host_i.tick(20);
        `CHK(n_runs, 2)
        `CHK(calibration_control, 16'h0000)
        host_i.ser_write({8'h00, 16'h8000});
        host_i.tick(30);
        `CHK(n_runs, 3)
        `CHK(ctl_at_start, 16'h8000)
        `CHK(calibration_control, 16'h0000)
        final_report();
    end

    // Cuts a hang short; the tests need about 740 cycles.
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
endmodule : tb
